// >>> bench/floppy_ctrl_status_handshake_sva.sv
// Concurrent checks on the bus and drive pins of the floppy block
`timescale 1ns/10ps
`default_nettype none
module floppy_ctrl_status_handshake_sva
	import fdc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic csN,
	input wire logic rdN,
	input wire logic dataOe,
	input wire logic headSelect,
	input wire logic oscSyncOutput,
	input wire logic stepPulse,
	input wire logic stepOutward
);
	logic [15:0] hiCnt;
	logic [15:0] loCnt;
	// Lengths of the step pulse and of the sync-low stretch
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hiCnt <= 16'h0000;
			loCnt <= 16'h0000;
		end else begin
			hiCnt <= stepPulse ? hiCnt + 16'h0001 : 16'h0000;
			loCnt <= oscSyncOutput ? 16'h0000 : loCnt + 16'h0001;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	sequence s_busIdle;
		csN [*5];
	endsequence
	sequence s_stepHeld;
		stepPulse ##1 stepPulse;
	endsequence
	property p_oeRise;
		$rose(dataOe) |-> $past(!csN && !rdN, 3);
	endproperty
	property p_oeFall;
		$fell(dataOe) |-> $past(csN || rdN, 3);
	endproperty
	property p_idleOff;
		s_busIdle |-> !dataOe;
	endproperty
	property p_stepLen;
		$fell(stepPulse) |-> hiCnt == STEP_PULSE_CYC;
	endproperty
	property p_stepHead;
		stepPulse |-> !headSelect;
	endproperty
	property p_stepDir;
		s_stepHeld |-> $stable(stepOutward);
	endproperty
	property p_gapMin;
		$rose(oscSyncOutput) |-> loCnt >= 16'h0140;
	endproperty
	property p_seekSync;
		stepPulse |-> oscSyncOutput;
	endproperty
	a_oeRise: assert property (p_oeRise)
		else $error("bus driven without a read");
	a_oeFall: assert property (p_oeFall)
		else $error("bus released during a read");
	a_idleOff: assert property (p_idleOff)
		else $error("bus driven while deselected");
	a_stepLen: assert property (p_stepLen)
		else $error("step pulse length wrong");
	a_stepHead: assert property (p_stepHead)
		else $error("head select high while stepping");
	a_stepDir: assert property (p_stepDir)
		else $error("step direction moved in a pulse");
	a_gapMin: assert property (p_gapMin)
		else $error("sync low shorter than the crc bytes");
	a_seekSync: assert property (p_seekSync)
		else $error("sync low while stepping");
endmodule
bind floppy_ctrl_status_handshake floppy_ctrl_status_handshake_sva
	floppy_ctrl_status_handshake_sva_i (.clk_sys(clk_sys), .rstn(rstn),
	.csN(csN), .rdN(rdN), .dataOe(dataOe), .headSelect(headSelect),
	.oscSyncOutput(oscSyncOutput), .stepPulse(stepPulse),
	.stepOutward(stepOutward));
`default_nettype wire

// >>> bench/host_model.sv
// Host processor model that drives the parallel bus strobes
`timescale 1ns/10ps
`default_nettype none
module host_model
	import fdc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] dataOut,
	output var logic csN,
	output var logic rdN,
	output var logic wrN,
	output var logic a0,
	output var logic [7:0] dataIn
);
	// Idle bus at time zero
	initial begin
		csN = 1'b1;
		rdN = 1'b1;
		wrN = 1'b1;
		a0 = 1'b0;
		dataIn = 8'hFF;
	end
	// Strobe held five cycles so the synced view settles
	task automatic busRead(input logic sel, output logic [7:0] d);
		@(negedge clk_sys);
		a0 = sel;
		csN = 1'b0;
		rdN = 1'b0;
		repeat (5) @(negedge clk_sys);
		d = dataOut;
		rdN = 1'b1;
		csN = 1'b1;
		repeat (6) @(negedge clk_sys);
	endtask
	// Released data lines show the inverse, not a stale copy
	task automatic busWrite(input logic [7:0] d);
		@(negedge clk_sys);
		a0 = 1'b1;
		dataIn = d;
		csN = 1'b0;
		wrN = 1'b0;
		repeat (5) @(negedge clk_sys);
		wrN = 1'b1;
		csN = 1'b1;
		dataIn = ~d;
		repeat (6) @(negedge clk_sys);
	endtask
	// Status polled before each byte; no settle wait in execution
	task automatic waitReady(input logic settle, output logic [7:0] s);
		s = 8'h00;
		for (int i = 0; i < 400 && !s[MSR_READY_BIT]; i++) begin
			if (settle)
				repeat (FLAG_UPDATE_MAX_CYC) @(negedge clk_sys);
			busRead(1'b0, s);
		end
	endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the floppy status and handshake block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import fdc_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic csN, rdN, wrN, a0, dataOe, diskWrStrobe, headSelect;
	logic oscSyncOutput, stepPulse, stepOutward;
	logic [1:0] driveNumber;
	logic [7:0] dataIn, dataOut, diskWrData, s, v;
	logic driveReady = 1'b1;
	logic driveFault = 1'b0;
	logic twoSided = 1'b1;
	logic trackZero = 1'b0;
	logic [7:0] diskRdData = 8'hA5;
	logic [7:0] errSt0 [3] = '{8'h4A, 8'h4E, 8'h52};
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int lowCycles = 0;
	int nStrobes = 0;

	// Clock of 100 ns period
	always #50 clk_sys = ~clk_sys;

	// Short step period keeps seeks brief
	floppy_ctrl_status_handshake #(.STEP_CYCLES(1000))
	floppy_ctrl_status_handshake_i (.clk_sys(clk_sys), .rstn(rstn),
		.csN(csN), .rdN(rdN), .wrN(wrN), .a0(a0), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .driveReady(driveReady),
		.driveFault(driveFault), .trackZeroInput(trackZero),
		.twoSided(twoSided), .writeProtect(1'b0),
		.diskRdData(diskRdData), .diskWrData(diskWrData),
		.diskWrStrobe(diskWrStrobe), .headSelect(headSelect),
		.driveNumber(driveNumber), .oscSyncOutput(oscSyncOutput),
		.stepPulse(stepPulse), .stepOutward(stepOutward));
	host_model host_model_i (.clk_sys(clk_sys), .dataOut(dataOut),
		.csN(csN), .rdN(rdN), .wrN(wrN), .a0(a0), .dataIn(dataIn));

	task automatic final_report();
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [7:0] b);
		host_model_i.waitReady(1'b1, s);
		host_model_i.busWrite(b);
	endtask
	// Read every result byte, checking the first and the end status
	task automatic drain(input logic [7:0] exp0, input logic [7:0] expEnd);
		host_model_i.waitReady(1'b1, s);
		check(s, {4'hD, expEnd[3:0]});
		host_model_i.busRead(1'b1, v);
		check(v, exp0);
		for (int i = 0; i < 8; i++) begin
			repeat (FLAG_UPDATE_MAX_CYC) @(negedge clk_sys);
			host_model_i.busRead(1'b0, s);
			if (s[7:6] !== 2'b11)
				break;
			host_model_i.busRead(1'b1, v);
		end
		check(s, expEnd);
	endtask
	task automatic rw(input logic [4:0] op, input logic [1:0] unit,
			input logic hd);
		send({3'h0, op});
		send({5'h00, hd, unit});
		send(8'h07);
		send({7'h00, hd});
		send(8'h01);
		send(8'h00);
		send(8'h01);
		send(8'h02);
		send(8'h02);
	endtask
	// Sync-low cycles and disk write strobes, sampled off the active edge
	always @(negedge clk_sys) begin
		if (oscSyncOutput === 1'b0)
			lowCycles++;
		if (diskWrStrobe === 1'b1)
			nStrobes++;
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			$display("mismatch at %0t: run too long", $time);
			final_report();
		end
	end

	initial begin
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (3) @(negedge clk_sys);
		host_model_i.busRead(1'b0, s);
		check(s, MSR_RESET);
		// Unknown opcode and idle sense interrupt both answer invalid
		send(8'h1F);
		drain(ST0_INVALID, MSR_RESET);
		send({3'h0, OP_SENSE_INT});
		drain(ST0_INVALID, MSR_RESET);
		// A read to drive 1 is refused while it seeks to track 5
		send({3'h0, OP_SEEK});
		send(8'h01);
		send(8'h05);
		rw(OP_READ, 2'h1, 1'b0);
		drain(8'h41, 8'h82);
		for (int i = 0; i < 1000 && s[1] !== 1'b0; i++)
			host_model_i.busRead(1'b0, s);
		check(s, MSR_RESET);
		send({3'h0, OP_SENSE_INT});
		drain(8'h21, MSR_RESET);
		// Recalibrate with track zero already seen, then sense the drive
		trackZero = 1'b1;
		send({3'h0, OP_RECAL});
		send(8'h01);
		send({3'h0, OP_SENSE_INT});
		drain(8'h21, MSR_RESET);
		send({3'h0, OP_SENSE_DRIVE});
		send(8'h06);
		drain(8'h3E, MSR_RESET);
		// Two-byte sector on head 1, then the sync gap and results
		rw(OP_READ, 2'h0, 1'b1);
		for (int i = 0; i < 2; i++) begin
			host_model_i.waitReady(1'b0, s);
			check(s, 8'hF0);
			host_model_i.busRead(1'b1, v);
			check(v, diskRdData);
		end
		check({5'h00, headSelect, driveNumber}, 8'h04);
		drain(8'h04, MSR_RESET);
		// Two CRC bytes plus a gap of two, in tens of cycles
		check(8'(lowCycles / 10), 8'((2 + 2) * BYTE_TIME_US * CLK_MHZ / 10));
		// Two-byte write on drive 3: host bytes reach the disk side
		rw(OP_WRITE, 2'h3, 1'b0);
		for (int i = 0; i < 2; i++) begin
			host_model_i.waitReady(1'b0, s);
			check(s, 8'hB0);
			host_model_i.busWrite(8'h3C + 8'(i));
		end
		drain(8'h03, MSR_RESET);
		check(diskWrData, 8'h3D);
		check(8'(nStrobes), 8'h02);
		// Not ready, single-sided head 1 and a drive fault on drive 2
		for (int k = 0; k < 3; k++) begin
			driveReady = (k != 0);
			twoSided = (k != 1);
			driveFault = (k == 2);
			repeat (4) @(negedge clk_sys);
			rw(OP_READ, 2'h2, k == 1);
			drain(errSt0[k], MSR_RESET);
			check({6'h00, driveNumber}, 8'h02);
		end
		final_report();
	end
endmodule
`default_nettype wire

// >>> design/fdc_pkg.sv
// Shared constants, field layouts and types for the floppy status block
package fdc_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 10;
	localparam int FLAG_UPDATE_MAX_US = 12;
	localparam int FLAG_UPDATE_MAX_CYC = FLAG_UPDATE_MAX_US * CLK_MHZ;
	localparam int BYTE_TIME_US = 16;
	localparam logic [7:0] BYTE_TIME_CYC = 8'(BYTE_TIME_US * CLK_MHZ - 1);
	localparam int STEP_RATE_US = 3000;
	localparam int STEP_RATE_CYC = STEP_RATE_US * CLK_MHZ;
	localparam int STEP_PULSE_US = 8;
	localparam logic [15:0] STEP_PULSE_CYC = 16'(STEP_PULSE_US * CLK_MHZ);
	localparam logic [8:0] RECAL_MAX_STEPS = 9'h100;
	localparam logic [8:0] CRC_BYTES = 9'h002;
	localparam logic [14:0] SECTOR_BASE_BYTES = 15'h0080;

	// Handshake status register fields
	localparam int MSR_READY_BIT = 7;
	localparam int MSR_DIR_BIT = 6;
	localparam int MSR_EXEC_BIT = 5;
	localparam int MSR_BUSY_BIT = 4;
	localparam logic [7:0] MSR_RESET = 8'h80;

	// Result status 0 fields
	localparam int ST0_CODE_LSB = 6;
	localparam int ST0_SEEK_BIT = 5;
	localparam int ST0_FAULT_BIT = 4;
	localparam int ST0_NOTREADY_BIT = 3;
	localparam int ST0_HEAD_BIT = 2;
	localparam logic [1:0] CODE_NORMAL = 2'h0;
	localparam logic [1:0] CODE_ABNORMAL = 2'h1;
	localparam logic [1:0] CODE_INVALID = 2'h2;
	localparam logic [1:0] CODE_READY_CHANGED = 2'h3;
	localparam logic [7:0] ST0_INVALID = 8'h80;

	// Command opcodes (low five bits of the first byte) and lengths
	localparam logic [4:0] OP_SENSE_DRIVE = 5'h04;
	localparam logic [4:0] OP_WRITE = 5'h05;
	localparam logic [4:0] OP_READ = 5'h06;
	localparam logic [4:0] OP_RECAL = 5'h07;
	localparam logic [4:0] OP_SENSE_INT = 5'h08;
	localparam logic [4:0] OP_SEEK = 5'h0F;
	localparam logic [3:0] LEN_RW = 4'h9;
	localparam logic [3:0] LEN_SEEK = 4'h3;
	localparam logic [3:0] LEN_TWO = 4'h2;
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [2:0] RES_RW = 3'h7;
	localparam logic [2:0] RES_SENSE_INT = 3'h2;
	localparam logic [2:0] RES_ONE = 3'h1;

	// Command byte positions for read and write
	localparam int CB_UNIT = 1;
	localparam int CB_CYL = 2;
	localparam int CB_HEAD = 3;
	localparam int CB_SECTOR = 4;
	localparam int CB_SIZE = 5;
	localparam int CB_LAST = 6;
	localparam int CB_GAP = 7;
	localparam int CB_DLEN = 8;

	typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RESULT} phase_t;

	typedef struct packed {
		logic csN;
		logic rdN;
		logic wrN;
		logic a0;
		logic [7:0] data;
	} host_pins_t;

	typedef struct packed {
		logic ready;
		logic fault;
		logic trackZero;
		logic twoSided;
		logic writeProtect;
	} drive_in_t;

	localparam int PIN_W = $bits(host_pins_t) + $bits(drive_in_t);
	localparam logic [PIN_W-1:0] PIN_IDLE = {4'hE, 8'h00, 5'h00};
endpackage

// >>> design/floppy_ctrl_status_handshake.sv
// Host handshake, command sequencing and result status of the floppy block
`timescale 1ns/10ps
`default_nettype none
module floppy_ctrl_status_handshake
	import fdc_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = STEP_RATE_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic a0,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOe,
	input wire logic driveReady,
	input wire logic driveFault,
	input wire logic trackZeroInput,
	input wire logic twoSided,
	input wire logic writeProtect,
	input wire logic [7:0] diskRdData,
	output logic [7:0] diskWrData,
	output logic diskWrStrobe,
	output logic headSelect,
	output logic [1:0] driveNumber,
	output logic oscSyncOutput,
	output logic stepPulse,
	output logic stepOutward
);
	// Byte count of one sector from size code and data length
	function automatic logic [14:0] sectorBytes(input logic [7:0] sizeCode,
			input logic [7:0] dataLen);
		logic [2:0] shift;
		shift = (sizeCode > 8'h07) ? 3'h7 : sizeCode[2:0];
		if (sizeCode == 8'h00)
			return {7'h00, dataLen};
		return 15'(SECTOR_BASE_BYTES << shift);
	endfunction

	// Number of bytes in a command, from its first byte
	function automatic logic [3:0] cmdLength(input logic [4:0] op);
		case (op)
			OP_READ, OP_WRITE: return LEN_RW;
			OP_SEEK: return LEN_SEEK;
			OP_RECAL, OP_SENSE_DRIVE: return LEN_TWO;
			default: return LEN_ONE;
		endcase
	endfunction

	logic [PIN_W-1:0] syncPins;
	host_pins_t hp;
	drive_in_t dv;

	// Every host bus and drive status pin passes two flops before any logic sees it; diskRdData is used directly
	pin_sync #(.W(PIN_W), .INIT(PIN_IDLE)) pinSync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pinIn({csN, rdN, wrN, a0, dataIn, driveReady, driveFault,
			trackZeroInput, twoSided, writeProtect}),
		.pinOut(syncPins)
	);
	assign {hp, dv} = syncPins;

	logic rdLow, wrLow, rdPrev, wrPrev, a0Held, rdEnd, wrEnd;
	logic [7:0] wrByte;
	phase_t phase;
	logic xferReady, xferDir, waitHost, readyAtStart, byteTick;
	logic [3:0] cmdIdx;
	logic [7:0] cmdBuf [0:8];
	logic [7:0] resBuf [0:6];
	logic [2:0] resIdx, resLen;
	logic [14:0] byteCnt;
	logic [8:0] gapLeft;
	logic [7:0] sector, dataReg, byteTimer, host_handshake_status;
	logic seekStart, seekRecal, senseAck;
	logic [1:0] seekReqDrive;
	logic [7:0] seekReqTarget;
	logic seekActive, seekFailed, stepIsRecal, pendValid;
	logic [1:0] seekDrive;
	logic [7:0] seekTarget, pendSt0, pendTrack;
	logic [7:0] trackPos [0:3];
	logic [8:0] stepCount;
	logic [15:0] stepTimer;
	logic [3:0] driveBusy;
	logic [4:0] opcode;
	logic [1:0] unit;
	logic head, badSide, doneRw, doneFault, gapEnd, gapStart;
	logic [1:0] doneCode;

	assign rdLow = !hp.csN && !hp.rdN;
	assign wrLow = !hp.csN && !hp.wrN;
	assign rdEnd = rdPrev && !rdLow;
	assign wrEnd = wrPrev && !wrLow;
	assign opcode = cmdBuf[0][4:0];
	assign unit = cmdBuf[CB_UNIT][1:0];
	assign head = cmdBuf[CB_UNIT][2];
	assign badSide = head && !dv.twoSided;
	assign gapEnd = (gapLeft == 9'h001) && byteTick;
	// Last host byte of a sector opens the CRC and gap stretch
	assign gapStart = (phase == PH_EXEC) && !doneRw && (gapLeft == 9'h000) &&
		waitHost && (rdEnd || wrEnd) && a0Held && (byteCnt == 15'h0001);

	// Strobe trailing edges; address and write data held from the strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdPrev <= 1'b0;
			wrPrev <= 1'b0;
			a0Held <= 1'b0;
			wrByte <= 8'h00;
		end else begin
			rdPrev <= rdLow;
			wrPrev <= wrLow;
			if (rdLow || wrLow)
				a0Held <= hp.a0;
			if (wrLow)
				wrByte <= hp.data;
		end
	end

	// Busy flag per drive while its head is moving
	always_comb begin
		driveBusy = 4'h0;
		if (seekActive)
			driveBusy[seekDrive] = 1'b1;
	end

	// Handshake status image, refreshed every cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			host_handshake_status <= MSR_RESET;
		end else begin
			host_handshake_status[MSR_READY_BIT] <= xferReady;
			host_handshake_status[MSR_DIR_BIT] <= xferDir;
			host_handshake_status[MSR_EXEC_BIT] <= (phase == PH_EXEC);
			host_handshake_status[MSR_BUSY_BIT] <= (phase != PH_CMD) || (cmdIdx != 4'h0);
			host_handshake_status[3:0] <= driveBusy;
		end
	end

	// Read data path; drives the bus one cycle behind the synced read strobe, for as long as it stays low
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dataOut <= 8'h00;
			dataOe <= 1'b0;
		end else begin
			dataOe <= rdLow;
			if (!hp.a0)
				dataOut <= host_handshake_status;
			else if (phase == PH_RESULT)
				dataOut <= resBuf[resIdx];
			else
				dataOut <= dataReg;
		end
	end

	// Byte-time enable for disk data and gap timing
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			byteTimer <= BYTE_TIME_CYC;
			byteTick <= 1'b0;
		end else begin
			byteTick <= (phase == PH_EXEC) && (byteTimer == 8'h00) &&
				!gapStart;
			// Realigned at gap start so no gap byte is a partial one
			if (phase != PH_EXEC || byteTimer == 8'h00 || gapStart)
				byteTimer <= BYTE_TIME_CYC;
			else
				byteTimer <= byteTimer - 8'h01;
		end
	end

	// End of a read or write and how it ended
	always_comb begin
		doneRw = 1'b0;
		doneCode = CODE_NORMAL;
		doneFault = 1'b0;
		if (phase == PH_EXEC) begin
			if (dv.fault) begin
				doneRw = 1'b1;
				doneCode = CODE_ABNORMAL;
				doneFault = 1'b1;
			end else if (dv.ready != readyAtStart) begin
				doneRw = 1'b1;
				doneCode = CODE_READY_CHANGED;
			end else if (gapEnd && sector == cmdBuf[CB_LAST]) begin
				doneRw = 1'b1;
			end
		end
	end

	// Command, execution and result sequencing
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase <= PH_CMD;
			xferReady <= 1'b1;
			xferDir <= 1'b0;
			waitHost <= 1'b0;
			readyAtStart <= 1'b0;
			cmdIdx <= 4'h0;
			for (int i = 0; i < 9; i++)
				cmdBuf[i] <= 8'h00;
			for (int i = 0; i < 7; i++)
				resBuf[i] <= 8'h00;
			resIdx <= 3'h0;
			resLen <= 3'h0;
			byteCnt <= 15'h0000;
			gapLeft <= 9'h000;
			oscSyncOutput <= 1'b1;
			sector <= 8'h00;
			dataReg <= 8'h00;
			diskWrData <= 8'h00;
			diskWrStrobe <= 1'b0;
			seekStart <= 1'b0;
			seekRecal <= 1'b0;
			seekReqDrive <= 2'h0;
			seekReqTarget <= 8'h00;
			senseAck <= 1'b0;
		end else begin
			diskWrStrobe <= 1'b0;
			seekStart <= 1'b0;
			senseAck <= 1'b0;
			case (phase)
				PH_CMD: begin
					// Ready drops for one cycle after each byte is taken and returns the cycle after that, except the last byte of a read or write
					xferReady <= !(wrEnd && a0Held);
					xferDir <= 1'b0;
					if (wrEnd && a0Held && xferReady) begin
						cmdBuf[cmdIdx] <= wrByte;
						if ((cmdIdx == 4'h0 &&
								cmdLength(wrByte[4:0]) == LEN_ONE) ||
								(cmdIdx != 4'h0 &&
								cmdIdx + 4'h1 == cmdLength(opcode))) begin
							cmdIdx <= 4'h0;
							xferReady <= 1'b0;
							// Last byte in hand: act on the whole command
							case (cmdIdx == 4'h0 ? wrByte[4:0] : opcode)
								OP_READ, OP_WRITE: begin
									if (driveBusy[unit]) begin
										resBuf[0] <= {CODE_ABNORMAL, 3'h0, head,
											unit};
										resLen <= RES_ONE;
										phase <= PH_RESULT;
									end else if (!dv.ready || badSide) begin
										resBuf[0] <= {CODE_ABNORMAL, 2'h0, 1'b1,
											head, unit};
										resLen <= RES_ONE;
										phase <= PH_RESULT;
									end else begin
										phase <= PH_EXEC;
										readyAtStart <= dv.ready;
										sector <= cmdBuf[CB_SECTOR];
										byteCnt <= sectorBytes(cmdBuf[CB_SIZE],
											wrByte);
										waitHost <= 1'b0;
									end
								end
								OP_SEEK, OP_RECAL: begin
									seekStart <= 1'b1;
									seekRecal <= (opcode == OP_RECAL);
									seekReqDrive <= (opcode == OP_RECAL) ?
										wrByte[1:0] : unit;
									seekReqTarget <= (opcode == OP_RECAL) ?
										8'h00 : wrByte;
								end
								OP_SENSE_DRIVE: begin
									resBuf[0] <= {dv.fault, dv.writeProtect,
										dv.ready, dv.trackZero, dv.twoSided,
										wrByte[2:0]};
									resLen <= RES_ONE;
									phase <= PH_RESULT;
								end
								OP_SENSE_INT: begin
									resBuf[0] <= pendValid ? pendSt0 :
										ST0_INVALID;
									resBuf[1] <= pendTrack;
									resLen <= pendValid ? RES_SENSE_INT :
										RES_ONE;
									senseAck <= pendValid;
									phase <= PH_RESULT;
								end
								default: begin
									resBuf[0] <= ST0_INVALID;
									resLen <= RES_ONE;
									phase <= PH_RESULT;
								end
							endcase
						end else begin
							cmdIdx <= cmdIdx + 4'h1;
						end
					end
				end
				PH_EXEC: begin
					xferDir <= (opcode == OP_READ);
					if (doneRw) begin
						// Results: code, flags, head and drive, then address
						resBuf[0] <= {doneCode, 1'b0, doneFault, 1'b0, head,
							unit};
						resBuf[1] <= 8'h00;
						resBuf[2] <= 8'h00;
						resBuf[3] <= cmdBuf[CB_CYL];
						resBuf[4] <= cmdBuf[CB_HEAD];
						resBuf[5] <= sector;
						resBuf[6] <= cmdBuf[CB_SIZE];
						resLen <= RES_RW;
						gapLeft <= 9'h000;
						oscSyncOutput <= 1'b1;
						xferReady <= 1'b0;
						waitHost <= 1'b0;
						phase <= PH_RESULT;
					end else if (gapLeft != 9'h000) begin
						if (byteTick)
							gapLeft <= gapLeft - 9'h001;
						if (gapEnd) begin
							oscSyncOutput <= 1'b1;
							sector <= sector + 8'h01;
							byteCnt <= sectorBytes(cmdBuf[CB_SIZE],
								cmdBuf[CB_DLEN]);
						end
					end else if (waitHost) begin
						if ((rdEnd || wrEnd) && a0Held) begin
							xferReady <= 1'b0;
							waitHost <= 1'b0;
							byteCnt <= byteCnt - 15'h0001;
							if (wrEnd) begin
								diskWrData <= wrByte;
								diskWrStrobe <= 1'b1;
							end
							// Sector done: CRC bytes then the gap, sync low
							if (byteCnt == 15'h0001) begin
								gapLeft <= CRC_BYTES + {1'b0,
									cmdBuf[CB_GAP]};
								oscSyncOutput <= 1'b0;
							end
						end
					end else if (byteTick) begin
						// Without DMA each byte is paced by the host
						if (opcode == OP_READ)
							dataReg <= diskRdData;
						xferReady <= 1'b1;
						waitHost <= 1'b1;
					end
				end
				PH_RESULT: begin
					xferDir <= 1'b1;
					xferReady <= !(rdEnd && a0Held);
					if (rdEnd && a0Held && xferReady) begin
						if (resIdx + 3'h1 >= resLen) begin
							resIdx <= 3'h0;
							xferDir <= 1'b0;
							phase <= PH_CMD;
						end else begin
							resIdx <= resIdx + 3'h1;
						end
					end
				end
				default: begin
					phase <= PH_CMD;
				end
			endcase
		end
	end

	// Head positioning runs in the background; drive select stays on the moving drive and a second seek is ignored
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			seekActive <= 1'b0;
			stepIsRecal <= 1'b0;
			seekDrive <= 2'h0;
			seekTarget <= 8'h00;
			seekFailed <= 1'b0;
			stepCount <= 9'h000;
			stepTimer <= 16'h0000;
			stepPulse <= 1'b0;
			stepOutward <= 1'b0;
			pendValid <= 1'b0;
			pendSt0 <= 8'h00;
			pendTrack <= 8'h00;
			for (int i = 0; i < 4; i++)
				trackPos[i] <= 8'h00;
		end else begin
			if (senseAck)
				pendValid <= 1'b0;
			if (seekStart && !seekActive) begin
				seekActive <= 1'b1;
				stepIsRecal <= seekRecal;
				seekDrive <= seekReqDrive;
				seekTarget <= seekReqTarget;
				stepCount <= 9'h000;
				stepTimer <= 16'h0000;
			end else if (seekActive) begin
				stepPulse <= (stepTimer > 16'(STEP_CYCLES) - STEP_PULSE_CYC);
				if (stepTimer != 16'h0000) begin
					stepTimer <= stepTimer - 16'h0001;
				end else if ((stepIsRecal && (dv.trackZero ||
						stepCount == RECAL_MAX_STEPS)) ||
						(!stepIsRecal && trackPos[seekDrive] == seekTarget)) begin
					// Finishing wins over a same-cycle sense acknowledge
					seekFailed <= stepIsRecal && !dv.trackZero;
					seekActive <= 1'b0;
					pendValid <= 1'b1;
					pendSt0 <= {(stepIsRecal && !dv.trackZero) ?
						CODE_ABNORMAL : CODE_NORMAL, 1'b1,
						stepIsRecal && !dv.trackZero,
						2'h0, seekDrive};
					pendTrack <= (stepIsRecal && dv.trackZero) ? 8'h00 :
						trackPos[seekDrive];
					if (stepIsRecal && dv.trackZero)
						trackPos[seekDrive] <= 8'h00;
				end else begin
					stepTimer <= 16'(STEP_CYCLES);
					stepCount <= stepCount + 9'h001;
					stepOutward <= stepIsRecal ||
						(seekTarget < trackPos[seekDrive]);
					if (!stepIsRecal && seekTarget < trackPos[seekDrive])
						trackPos[seekDrive] <= trackPos[seekDrive] - 8'h01;
					else if (!stepIsRecal)
						trackPos[seekDrive] <= trackPos[seekDrive] + 8'h01;
				end
			end else begin
				stepPulse <= 1'b0;
			end
		end
	end

	// Drive and head select follow the moving drive, else the command
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			headSelect <= 1'b0;
			driveNumber <= 2'h0;
		end else if (seekActive) begin
			headSelect <= 1'b0;
			driveNumber <= seekDrive;
		end else begin
			headSelect <= head;
			driveNumber <= unit;
		end
	end
endmodule
`default_nettype wire

// >>> design/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [W-1:0] pinIn,
	output var logic [W-1:0] pinOut
);
	logic [W-1:0] stage1;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage1 <= INIT;
			pinOut <= INIT;
		end else begin
			stage1 <= pinIn;
			pinOut <= stage1;
		end
	end
endmodule
`default_nettype wire
